// File: core/seid_dev.sv
// serial eeprom memory side: page write, ecc, id page and lock
// Summary of operation
// - held select keeps page write collecting bytes
// - only in-page offset advances, wraps to zero
// - write ignored: no latch, busy, off-boundary, protected
// - write cycle erases then programs, erased reads 0
// - four-byte groups carry single-error correcting code
// - partial group write rewrites whole group
// - id read uses six offset bits, increments
// - id read offset wraps to zero inside the page
// - id read refused while write busy
// - id write uses six offset bits only
// - lock status byte lsb shows lock
// - lock status byte repeats while selected
// - lock needs write enable and data bit1
// - lock needs select rise right after byte
// - valid lock starts self-timed write cycle
// - lock discarded: busy, bp 11, off-boundary, no latch
// - lock is permanent
// - power-up: idle, latch and busy clear, fall needed
// - protect and disable bits survive power cycles
// - delivered array all ones, status bits zero
// - busy flag during cycle, clears with latch unless a write enable ends in that cycle
`timescale 1ns/1ps
module seid_dev #(
	parameter int MEM_BYTES = seid_pkg::MAIN_BYTES, // main array bytes
	parameter int TW = seid_pkg::TW_CYCLES // write cycle length in aclk cycles
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // power-up reset, active low
	seid_if.dev spi // serial bus, memory side
);
	localparam int AW = $clog2(MEM_BYTES);
	localparam int MW = MEM_BYTES / 4;
	localparam int IW = $clog2(MW + 16);
	localparam int TWW = $clog2(TW + 1);

	if (MEM_BYTES < 2048 || (1 << AW) != MEM_BYTES || AW > 16 || TW < 64)
	begin : g_bad_param
		$error("seid_dev: unsupported size or write time");
	end

	typedef struct packed {
		logic cs1, cs2, csd;
		logic sck1, sck2, sckd;
		logic mo1, mo2;
		logic act;
		logic [2:0] bcnt;
		logic [2:0] nby;
		logic [7:0] rx;
		logic [7:0] op;
		logic [15:0] addr;
		logic [7:0] tx;
		logic ok;
		logic miso;
		logic lockdat;
		logic write_enable_latch;
		logic write_in_progress_flag;
		seid_pkg::seid_wc_e wc;
		seid_pkg::seid_kind_e kind;
		logic [3:0] grp;
		logic [IW-1:0] wbase;
		logic [31:0] wdat;
		logic [TWW-1:0] tmr;
		logic [7:0] psr;
		logic [63:0][7:0] pbuf;
		logic [63:0] pmask;
		logic lock;
		logic [1:0] bp;
		logic status_write_disable_bit;
	} seid_dev_s;

	seid_dev_s s_reg = '0;
	seid_dev_s n;
	logic [seid_pkg::ECC_W-1:0] mem [MW + 16];
	logic mem_we;
	logic [IW-1:0] mem_idx;
	logic [seid_pkg::ECC_W-1:0] mem_val;
	logic rise, fall, cs_rise, cs_fall, can_wr, id_sel, write_enable_command_done;
	logic [7:0] rx_next;
	logic [7:0] stat;
	logic [15:0] a_full;
	logic [IW-1:0] gidx;
	logic [3:0] gmask;
	logic [31:0] old_w, mer_w;

	initial
	begin
		for (int i = 0; i < MW + 16; i++)
			mem[i] = seid_pkg::ham_enc(seid_pkg::DELIVERED_WORD);
	end

	function automatic logic [IW-1:0] main_idx(input logic [15:0] a);
		return IW'(a[AW-1:2]);
	endfunction : main_idx

	function automatic logic [IW-1:0] id_idx(input logic [15:0] a);
		return IW'(MW) + IW'(a[5:2]);
	endfunction : id_idx

	function automatic logic [7:0] rd_byte(input logic [IW-1:0] wi, input logic [1:0] bi);
		logic [31:0] w;
		w = seid_pkg::ham_fix(mem[wi]);
		return w[{bi, 3'b000} +: 8];
	endfunction : rd_byte

	function automatic logic prot(input logic [15:0] a, input logic [1:0] bp);
		unique case (bp)
			2'h0: return 1'b0;
			2'h1: return &a[AW-1:AW-2];
			2'h2: return a[AW-1];
			2'h3: return 1'b1;
		endcase
	endfunction : prot

	always_comb
	begin
		n = s_reg;
		mem_we = 1'b0;
		mem_idx = '0;
		mem_val = '0;
		n.cs1 = spi.cs_n;
		n.cs2 = s_reg.cs1;
		n.csd = s_reg.cs2;
		n.sck1 = spi.sck;
		n.sck2 = s_reg.sck1;
		n.sckd = s_reg.sck2;
		n.mo1 = spi.mosi;
		n.mo2 = s_reg.mo1;
		rise = s_reg.sck2 & ~s_reg.sckd;
		fall = ~s_reg.sck2 & s_reg.sckd;
		cs_fall = ~s_reg.cs2 & s_reg.csd;
		cs_rise = s_reg.cs2 & ~s_reg.csd;
		write_enable_command_done = cs_rise && s_reg.act && s_reg.op == seid_pkg::OP_WRITE_ENABLE_COMMAND
			&& s_reg.nby == 3'h1 && s_reg.bcnt == 3'h0;
		rx_next = {s_reg.rx[6:0], s_reg.mo2};
		a_full = {s_reg.addr[15:8], rx_next};
		id_sel = s_reg.addr[seid_pkg::ID_SEL_POS];
		stat = {s_reg.status_write_disable_bit, 3'b000, s_reg.bp, s_reg.write_enable_latch, s_reg.write_in_progress_flag};
		can_wr = s_reg.write_enable_latch && !s_reg.write_in_progress_flag && s_reg.bcnt == 3'h0;
		gidx = s_reg.wbase + IW'(s_reg.grp);
		gmask = s_reg.pmask[{s_reg.grp, 2'b00} +: 4];
		old_w = seid_pkg::ham_fix(mem[gidx]);
		for (int b = 0; b < 4; b++)
			mer_w[8*b +: 8] = gmask[b] ? s_reg.pbuf[{s_reg.grp, 2'(b)}] : old_w[8*b +: 8];

		// frame framing: a falling select is the only way in
		if (cs_fall)
		begin
			n.act = 1'b1;
			n.bcnt = 3'h0;
			n.nby = 3'h0;
			n.ok = 1'b0;
			n.tx = 8'h00;
			n.lockdat = 1'b0;
			if (!s_reg.write_in_progress_flag)
				n.pmask = '0;
		end
		else if (s_reg.act && !s_reg.cs2 && rise)
		begin
			n.rx = rx_next;
			n.bcnt = s_reg.bcnt + 3'h1;
			if (s_reg.bcnt == 3'h7)
			begin
				n.nby = (s_reg.nby == 3'h7) ? 3'h7 : s_reg.nby + 3'h1;
				if (s_reg.nby == 3'h0)
				begin
					n.op = rx_next;
					n.ok = rx_next == seid_pkg::OP_RDSR;
					n.tx = stat;
				end
				else if (s_reg.op == seid_pkg::OP_RDSR)
					n.tx = stat;
				else if (s_reg.nby == 3'h1)
					n.addr[15:8] = rx_next;
				else if (s_reg.nby == 3'h2)
				begin
					n.addr = a_full;
					if (s_reg.op == seid_pkg::OP_READ)
					begin
						n.ok = !s_reg.write_in_progress_flag;
						n.tx = rd_byte(main_idx(a_full), a_full[1:0]);
					end
					else if (s_reg.op == seid_pkg::OP_RDID)
					begin
						n.ok = !s_reg.write_in_progress_flag;
						if (a_full[seid_pkg::ID_SEL_POS])
							n.tx = {7'h00, s_reg.lock};
						else
							n.tx = rd_byte(id_idx(a_full), a_full[1:0]);
					end
				end
				else
				begin
					// data byte phase
					unique case (s_reg.op)
						seid_pkg::OP_WRITE, seid_pkg::OP_WRID:
						begin
							if (s_reg.op == seid_pkg::OP_WRID && id_sel)
								n.lockdat = rx_next[1];
							else if (!s_reg.write_in_progress_flag)
							begin
								n.pbuf[s_reg.addr[5:0]] = rx_next;
								n.pmask[s_reg.addr[5:0]] = 1'b1;
								n.addr[5:0] = s_reg.addr[5:0] + 6'h01;
							end
						end
						seid_pkg::OP_READ:
						begin
							n.addr[AW-1:0] = s_reg.addr[AW-1:0] + AW'(1);
							n.tx = rd_byte(main_idx(n.addr), n.addr[1:0]);
						end
						seid_pkg::OP_RDID:
						begin
							if (id_sel)
								n.tx = {7'h00, s_reg.lock};
							else
							begin
								n.addr[5:0] = s_reg.addr[5:0] + 6'h01;
								n.tx = rd_byte(id_idx(n.addr), n.addr[1:0]);
							end
						end
						default:
						begin
						end
					endcase
				end
			end
		end
		else if (s_reg.act && !s_reg.cs2 && fall)
		begin
			n.miso = s_reg.tx[7] & s_reg.ok;
			n.tx = {s_reg.tx[6:0], 1'b0};
		end

		// commit decisions on the rising select
		if (cs_rise && s_reg.act)
		begin
			n.act = 1'b0;
			n.miso = 1'b0;
			n.grp = 4'h0;
			n.tmr = '0;
			n.psr = s_reg.addr[15:8];
			if (write_enable_command_done)
				n.write_enable_latch = 1'b1;
			else if (s_reg.op == seid_pkg::OP_WRDI && s_reg.nby == 3'h1 && s_reg.bcnt == 3'h0)
				n.write_enable_latch = 1'b0;
			else if (s_reg.op == seid_pkg::OP_WRITE && can_wr && s_reg.nby >= 3'h4
				&& !prot(s_reg.addr, s_reg.bp))
			begin
				n.write_in_progress_flag = 1'b1;
				n.kind = seid_pkg::K_MAIN;
				n.wc = seid_pkg::WC_ERASE;
				n.wbase = IW'({s_reg.addr[AW-1:6], 4'h0});
			end
			else if (s_reg.op == seid_pkg::OP_WRID && !id_sel && can_wr && s_reg.nby >= 3'h4
				&& !s_reg.lock)
			begin
				n.write_in_progress_flag = 1'b1;
				n.kind = seid_pkg::K_ID;
				n.wc = seid_pkg::WC_ERASE;
				n.wbase = IW'(MW);
			end
			else if (s_reg.op == seid_pkg::OP_WRID && id_sel && can_wr && s_reg.nby == 3'h4
				&& s_reg.bp != 2'h3 && s_reg.lockdat)
			begin
				n.write_in_progress_flag = 1'b1;
				n.kind = seid_pkg::K_LOCK;
				n.wc = seid_pkg::WC_WAIT;
			end
			else if (s_reg.op == seid_pkg::OP_WRSR && can_wr && s_reg.nby == 3'h2)
			begin
				n.write_in_progress_flag = 1'b1;
				n.kind = seid_pkg::K_SR;
				n.wc = seid_pkg::WC_WAIT;
			end
		end

		// self-timed cycle: per group erase then program, then wait out the time
		if (s_reg.write_in_progress_flag)
		begin
			n.tmr = s_reg.tmr + 1'b1;
			mem_idx = gidx;
			unique case (s_reg.wc)
				seid_pkg::WC_ERASE:
				begin
					n.wdat = mer_w;
					mem_we = |gmask;
					mem_val = seid_pkg::ham_enc(32'h00000000);
					n.wc = seid_pkg::WC_PROG;
				end
				seid_pkg::WC_PROG:
				begin
					mem_we = |gmask;
					mem_val = seid_pkg::ham_enc(s_reg.wdat);
					n.grp = s_reg.grp + 4'h1;
					n.wc = (s_reg.grp == 4'hf) ? seid_pkg::WC_WAIT : seid_pkg::WC_ERASE;
				end
				seid_pkg::WC_WAIT:
				begin
					if (s_reg.tmr >= TWW'(TW - 1))
					begin
						n.write_in_progress_flag = 1'b0;
						// a write enable landing in the same cycle keeps the latch set
						if (!write_enable_command_done)
							n.write_enable_latch = 1'b0;
						n.wc = seid_pkg::WC_IDLE;
						n.pmask = '0;
						if (s_reg.kind == seid_pkg::K_LOCK)
							n.lock = 1'b1;
						if (s_reg.kind == seid_pkg::K_SR)
						begin
							n.bp = s_reg.psr[3:2];
							n.status_write_disable_bit = s_reg.psr[7];
						end
					end
				end
				seid_pkg::WC_IDLE:
				begin
				end
			endcase
		end

		if (!aresetn)
		begin
			n = '0;
			n.cs1 = 1'b1;
			n.cs2 = 1'b1;
			n.csd = 1'b1;
			n.lock = s_reg.lock;
			n.bp = s_reg.bp;
			n.status_write_disable_bit = s_reg.status_write_disable_bit;
			mem_we = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		s_reg <= n;
	end

	always_ff @(posedge aclk)
	begin
		if (mem_we)
			mem[mem_idx] <= mem_val;
	end

	assign spi.miso = s_reg.miso;
endmodule : seid_dev

// File: include/seid_pkg.sv
// shared constants, types and ecc functions for the serial eeprom pair
package seid_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_RDID = 8'h83;
	localparam logic [7:0] OP_WRID = 8'h82;
	localparam int MAIN_BYTES = 32768;
	localparam int ID_SEL_POS = 10;
	localparam int ECC_W = 38;
	localparam logic [31:0] DELIVERED_WORD = 32'hffffffff;
	localparam int CLK_NS = 40;
	localparam int TW_NS = 5000000;
	localparam int TW_CYCLES = TW_NS / CLK_NS;
	localparam int SCK_HALF_NS = 160;
	localparam int SCK_HALF = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int CMD_ADDR_BIT = 8;
	localparam int CMD_END_BIT = 31;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {WC_IDLE, WC_ERASE, WC_PROG, WC_WAIT} seid_wc_e;
	typedef enum {K_MAIN, K_ID, K_LOCK, K_SR} seid_kind_e;
	typedef enum {H_IDLE, H_SEL, H_LOW, H_HIGH, H_HOLD, H_DESEL} seid_hst_e;

	function automatic logic [5:0] ham_syn(input logic [ECC_W-1:0] c);
		logic [5:0] s;
		s = '0;
		for (int p = 1; p <= ECC_W; p++)
			if (c[p-1])
				s = s ^ 6'(p);
		return s;
	endfunction : ham_syn

	function automatic logic [ECC_W-1:0] ham_enc(input logic [31:0] d);
		logic [ECC_W-1:0] c;
		logic [5:0] s;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p <= ECC_W; p++)
			if ((p & (p - 1)) != 0)
			begin
				c[p-1] = d[k];
				k++;
			end
		s = ham_syn(c);
		for (int i = 0; i < 6; i++)
			c[(1 << i) - 1] = s[i];
		return c;
	endfunction : ham_enc

	// single flipped bit anywhere in the codeword is repaired
	function automatic logic [31:0] ham_fix(input logic [ECC_W-1:0] cw);
		logic [ECC_W-1:0] c;
		logic [31:0] d;
		logic [5:0] s;
		int k;
		c = cw;
		d = '0;
		k = 0;
		s = ham_syn(cw);
		if (s != 6'h00 && int'(s) <= ECC_W)
			c[int'(s)-1] = ~c[int'(s)-1];
		for (int p = 1; p <= ECC_W; p++)
			if ((p & (p - 1)) != 0)
			begin
				d[k] = c[p-1];
				k++;
			end
		return d;
	endfunction : ham_fix
endpackage : seid_pkg

// File: include/seid_if.sv
// serial bus between host controller and eeprom
`timescale 1ns/1ps
interface seid_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	modport dev (input cs_n, input sck, input mosi, output miso);
	modport host (output cs_n, output sck, output mosi, input miso);
endinterface : seid_if

// File: core/seid_host.sv
// serial bus controller driven by software over axi4-lite
`timescale 1ns/1ps
module seid_host #(
	parameter int SCK_HALF = seid_pkg::SCK_HALF // aclk cycles per sck half period
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [7:0] s_axi_awaddr, // write byte address
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	output logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	input wire logic [7:0] s_axi_araddr, // read byte address
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	seid_if.host spi // serial bus, controller side
);
	if (SCK_HALF < 4 || SCK_HALF > 255)
	begin : g_bad_param
		$error("seid_host: SCK_HALF out of range");
	end

	typedef struct packed {
		logic awok, wok;
		logic [7:0] waddr;
		logic [31:0] wdat;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		seid_pkg::seid_hst_e st;
		logic [7:0] cnt;
		logic [4:0] nb;
		logic [23:0] sr;
		logic [7:0] rx;
		logic [15:0] addr;
		logic cs_n, sck, mosi;
		logic mi1, mi2;
	} seid_host_s;

	seid_host_s s_reg = '0;
	seid_host_s n;
	logic half_done;

	assign s_axi_awready = !s_reg.awok && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.wok && !s_reg.bvalid;
	assign s_axi_arready = !s_reg.rvalid;

	always_comb
	begin
		n = s_reg;
		n.mi1 = spi.miso;
		n.mi2 = s_reg.mi1;
		half_done = s_reg.cnt == 8'(SCK_HALF - 1);
		n.cnt = half_done ? 8'h00 : s_reg.cnt + 8'h01;
		if (s_reg.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (s_reg.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			n.awok = 1'b1;
			n.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			n.wok = 1'b1;
			n.wdat = s_axi_wdata;
			n.wstb = s_axi_wstrb[0];
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = seid_pkg::RESP_OKAY;
			n.rdata = 32'h00000000;
			unique case (s_axi_araddr)
				seid_pkg::REG_CMD: n.rdata = 32'h00000000;
				seid_pkg::REG_ADDR: n.rdata = {16'h0000, s_reg.addr};
				seid_pkg::REG_DATA: n.rdata = {24'h000000, s_reg.rx};
				seid_pkg::REG_STAT:
					n.rdata = {30'h0, s_reg.st == seid_pkg::H_HOLD, !s_reg.cs_n};
				default: n.rresp = seid_pkg::RESP_SLVERR;
			endcase
		end

		// bit engine: mosi moves with the falling sck, miso is taken late in the high phase
		unique case (s_reg.st)
			seid_pkg::H_IDLE, seid_pkg::H_HOLD:
				n.cnt = 8'h00;
			seid_pkg::H_SEL:
				if (half_done)
				begin
					n.st = seid_pkg::H_LOW;
					n.mosi = s_reg.sr[23];
				end
			seid_pkg::H_LOW:
				if (half_done)
				begin
					n.sck = 1'b1;
					n.st = seid_pkg::H_HIGH;
				end
			seid_pkg::H_HIGH:
				if (half_done)
				begin
					n.rx = {s_reg.rx[6:0], s_reg.mi2};
					n.sck = 1'b0;
					n.sr = {s_reg.sr[22:0], 1'b0};
					n.mosi = s_reg.sr[22];
					n.nb = s_reg.nb - 5'h01;
					// select stays low between bytes until software ends the frame
					n.st = (s_reg.nb == 5'h01) ? seid_pkg::H_HOLD : seid_pkg::H_LOW;
				end
			seid_pkg::H_DESEL:
				if (half_done)
					n.st = seid_pkg::H_IDLE;
		endcase

		if (s_reg.awok && s_reg.wok && !s_reg.bvalid)
		begin
			n.awok = 1'b0;
			n.wok = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = seid_pkg::RESP_SLVERR;
			if (s_reg.waddr == seid_pkg::REG_ADDR && s_reg.wstb)
			begin
				n.addr = s_reg.wdat[15:0];
				n.bresp = seid_pkg::RESP_OKAY;
			end
			else if (s_reg.waddr == seid_pkg::REG_CMD && s_reg.wstb)
			begin
				if (s_reg.wdat[seid_pkg::CMD_END_BIT] && s_reg.st == seid_pkg::H_HOLD)
				begin
					n.cs_n = 1'b1;
					n.st = seid_pkg::H_DESEL;
					n.cnt = 8'h00;
					n.bresp = seid_pkg::RESP_OKAY;
				end
				else if (!s_reg.wdat[seid_pkg::CMD_END_BIT] && s_reg.st == seid_pkg::H_IDLE)
				begin
					n.cs_n = 1'b0;
					n.sr = {s_reg.wdat[7:0], s_reg.addr};
					n.nb = s_reg.wdat[seid_pkg::CMD_ADDR_BIT] ? 5'd24 : 5'd8;
					n.st = seid_pkg::H_SEL;
					n.cnt = 8'h00;
					n.bresp = seid_pkg::RESP_OKAY;
				end
			end
			else if (s_reg.waddr == seid_pkg::REG_DATA && s_reg.wstb
				&& s_reg.st == seid_pkg::H_HOLD)
			begin
				n.sr = {s_reg.wdat[7:0], 16'h0000};
				n.mosi = s_reg.wdat[7];
				n.nb = 5'd8;
				n.st = seid_pkg::H_LOW;
				n.cnt = 8'h00;
				n.bresp = seid_pkg::RESP_OKAY;
			end
		end

		if (!aresetn)
		begin
			n = '0;
			n.st = seid_pkg::H_IDLE;
			n.cs_n = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		s_reg <= n;
	end

	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign spi.cs_n = s_reg.cs_n;
	assign spi.sck = s_reg.sck;
	assign spi.mosi = s_reg.mosi;
endmodule : seid_host

// File: bench/seid_link_props.sv
// wire-level checks on the serial link between controller and memory
`timescale 1ns/1ps
module seid_link_props #(
	parameter int SCK_HALF = 4 // aclk cycles per sck half period
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // reset, active low
	input wire logic cs_n, // select, active low
	input wire logic sck, // serial clock
	input wire logic mosi, // controller to memory data
	input wire logic miso // memory to controller data
);
	typedef struct packed {
		logic sck_d;
		logic [7:0] hi_cnt;
		logic [15:0] bit_cnt;
	} seid_chk_s;
	seid_chk_s st_reg;
	seid_chk_s st_next;

	// high phase length and rising edges seen inside the current frame
	always_comb
	begin
		st_next = st_reg;
		st_next.sck_d = sck;
		st_next.hi_cnt = sck ? st_reg.hi_cnt + 8'h01 : 8'h00;
		st_next.bit_cnt = cs_n ? 16'h0000 : st_reg.bit_cnt + 16'(sck & ~st_reg.sck_d);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	miso_quiet_a: assert property (cs_n [*5] |-> !miso)
		else $error("miso not low while deselected");
	sck_parked_a: assert property (cs_n |-> !sck)
		else $error("sck high while deselected");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while sck high");
	high_len_a: assert property ($fell(sck) |-> st_reg.hi_cnt == 8'(SCK_HALF))
		else $error("sck high phase has wrong length");
	byte_end_a: assert property ($rose(cs_n) |-> st_reg.bit_cnt[2:0] == 3'h0 && st_reg.bit_cnt >= 16'h0008)
		else $error("frame closed off a byte boundary");
	cs_lead_a: assert property ($fell(cs_n) |-> !sck [*4])
		else $error("sck rose too soon after select");
	miso_shift_a: assert property ($changed(miso) |-> !sck)
		else $error("miso changed while sck high");
	cs_rest_a: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("select pulse too short");

	one_byte_c: cover property ($rose(cs_n) && st_reg.bit_cnt == 16'h0020);
	cmd_only_c: cover property ($rose(cs_n) && st_reg.bit_cnt == 16'h0008);
	read_c: cover property ($rose(miso));
endmodule : seid_link_props

// File: bench/tb_top.sv
// bench joining controller and memory over the serial link
`timescale 1ns/1ps
module tb_top;
	localparam int TW = 1000;
	logic aclk;
	logic aresetn = 1'b0;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic aw_r, w_r, b_v, ar_r, r_v;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0] w_d = 32'h00000000;
	logic [31:0] r_d;
	logic [3:0] w_s = 4'hf;
	logic [1:0] b_s, r_s;
	logic [7:0] bt [4];
	int error_cnt = 0;
	int comparisons = 0;

	seid_if link ();
	seid_host #(.SCK_HALF(4)) u_seid_host (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_bresp(b_s), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d),
		.s_axi_rresp(r_s), .spi(link.host));
	seid_dev #(.MEM_BYTES(2048), .TW(TW)) u_seid_dev (.aclk(aclk), .aresetn(aresetn),
		.spi(link.dev));
	seid_link_props #(.SCK_HALF(4)) u_seid_link_props (.aclk(aclk), .aresetn(aresetn),
		.cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .miso(link.miso));

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic fail_wait;
		error_cnt++;
		$display("ERROR %0t wait ran out", $time);
		report_and_stop();
	endtask : fail_wait

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		aw_v <= 1'b1;
		aw_a <= a;
		w_v <= 1'b1;
		w_d <= d;
		b_r <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (aw_v && aw_r)
				aw_v <= 1'b0;
			if (w_v && w_r)
				w_v <= 1'b0;
			if (b_v && b_r)
				break;
		end
		if (n == 50)
			fail_wait();
		resp = b_s;
		b_r <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		ar_v <= 1'b1;
		ar_a <= a;
		r_r <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (ar_v && ar_r)
				ar_v <= 1'b0;
			if (r_v && r_r)
				break;
		end
		if (n == 50)
			fail_wait();
		d = r_d;
		resp = r_s;
		r_r <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	task automatic wait_hold;
		logic [31:0] s;
		logic [1:0] rs;
		int n;
		for (n = 0; n < 100; n++)
		begin
			axi_rd(seid_pkg::REG_STAT, s, rs);
			if (s[1] === 1'b1)
				break;
		end
		if (n == 100)
			fail_wait();
	endtask : wait_hold

	// one frame: opcode, optional address, nb bytes out of bt, replies back into bt
	task automatic xfer(input logic [7:0] op, input logic use_a, input logic [15:0] a, input int nb);
		logic [1:0] rs;
		logic [31:0] v;
		int n;
		axi_wr(seid_pkg::REG_ADDR, {16'h0000, a}, rs);
		for (n = 0; n < 20; n++)
		begin
			axi_wr(seid_pkg::REG_CMD, {23'h000000, use_a, op}, rs);
			if (rs === seid_pkg::RESP_OKAY)
				break;
		end
		if (n == 20)
			fail_wait();
		wait_hold();
		for (int i = 0; i < nb; i++)
		begin
			axi_wr(seid_pkg::REG_DATA, {24'h000000, bt[i]}, rs);
			wait_hold();
			axi_rd(seid_pkg::REG_DATA, v, rs);
			bt[i] = v[7:0];
		end
		axi_wr(seid_pkg::REG_CMD, 32'h80000000, rs);
	endtask : xfer

	task automatic write_enable_command;
		xfer(seid_pkg::OP_WRITE_ENABLE_COMMAND, 1'b0, 16'h0000, 0);
	endtask : write_enable_command

	task automatic status(output logic [7:0] s);
		bt[0] = 8'h00;
		xfer(seid_pkg::OP_RDSR, 1'b0, 16'h0000, 1);
		s = bt[0];
	endtask : status

	task automatic rd(input logic [7:0] op, input logic [15:0] a, input int nb);
		bt = '{default: 8'h00};
		xfer(op, 1'b1, a, nb);
	endtask : rd

	task automatic wait_ready;
		logic [7:0] s;
		int n;
		for (n = 0; n < 30; n++)
		begin
			status(s);
			if (s[0] === 1'b0)
				break;
		end
		if (n == 30)
			fail_wait();
	endtask : wait_ready

	task automatic sc_bus;
		logic [31:0] v;
		logic [1:0] rs;
		axi_rd(8'h10, v, rs);
		chk({6'h00, rs}, {6'h00, seid_pkg::RESP_SLVERR});
		chk(v[7:0], 8'h00);
		w_s <= 4'he;
		axi_wr(seid_pkg::REG_ADDR, 32'h00000000, rs);
		chk({6'h00, rs}, {6'h00, seid_pkg::RESP_SLVERR});
		w_s <= 4'hf;
	endtask : sc_bus

	task automatic sc_delivery;
		logic [7:0] s;
		status(s);
		chk(s, 8'h00);
		rd(seid_pkg::OP_READ, 16'h0123, 2);
		chk(bt[0], 8'hff);
		chk(bt[1], 8'hff);
		rd(seid_pkg::OP_RDID, 16'h0007, 1);
		chk(bt[0], 8'hff);
		rd(seid_pkg::OP_RDID, 16'h0400, 1);
		chk(bt[0], 8'h00);
		bt[0] = 8'h5a;
		xfer(seid_pkg::OP_WRITE, 1'b1, 16'h0040, 1);
		wait_ready();
		rd(seid_pkg::OP_READ, 16'h0040, 1);
		chk(bt[0], 8'hff);
	endtask : sc_delivery

	task automatic sc_page_wrap;
		logic [7:0] s;
		write_enable_command();
		status(s);
		chk(s, 8'h02);
		bt = '{8'ha1, 8'hb2, 8'hc3, 8'h00};
		xfer(seid_pkg::OP_WRITE, 1'b1, 16'h00be, 3);
		status(s);
		chk(s, 8'h03);
		rd(seid_pkg::OP_RDID, 16'h0005, 1);
		chk(bt[0], 8'h00);
		wait_ready();
		status(s);
		chk(s, 8'h00);
		rd(seid_pkg::OP_READ, 16'h0080, 2);
		chk(bt[0], 8'hc3);
		chk(bt[1], 8'hff);
		rd(seid_pkg::OP_READ, 16'h00be, 2);
		chk(bt[0], 8'ha1);
		chk(bt[1], 8'hb2);
	endtask : sc_page_wrap

	task automatic sc_id_page;
		write_enable_command();
		bt = '{8'h11, 8'h22, 8'h33, 8'h00};
		xfer(seid_pkg::OP_WRID, 1'b1, 16'h0305, 3);
		wait_ready();
		rd(seid_pkg::OP_RDID, 16'h0b06, 2);
		chk(bt[0], 8'h22);
		chk(bt[1], 8'h33);
	endtask : sc_id_page

	task automatic sc_lock;
		logic [7:0] s;
		bt[0] = 8'h02;
		xfer(seid_pkg::OP_WRID, 1'b1, 16'h0400, 1);
		rd(seid_pkg::OP_RDID, 16'h0400, 1);
		chk(bt[0], 8'h00);
		write_enable_command();
		bt[0] = 8'hfe;
		xfer(seid_pkg::OP_WRID, 1'b1, 16'h0400, 1);
		status(s);
		chk(s, 8'h03);
		wait_ready();
		rd(seid_pkg::OP_RDID, 16'h043f, 3);
		chk(bt[0], 8'h01);
		chk(bt[2], 8'h01);
		write_enable_command();
		bt[0] = 8'h99;
		xfer(seid_pkg::OP_WRID, 1'b1, 16'h0005, 1);
		wait_ready();
		rd(seid_pkg::OP_RDID, 16'h0005, 1);
		chk(bt[0], 8'h11);
	endtask : sc_lock

	task automatic sc_power;
		logic [7:0] s;
		write_enable_command();
		bt[0] = 8'h04;
		xfer(seid_pkg::OP_WRSR, 1'b0, 16'h0000, 1);
		wait_ready();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		status(s);
		chk(s, 8'h04);
		rd(seid_pkg::OP_RDID, 16'h0400, 1);
		chk(bt[0], 8'h01);
		write_enable_command();
		bt[0] = 8'h12;
		xfer(seid_pkg::OP_WRITE, 1'b1, 16'h0700, 1);
		wait_ready();
		rd(seid_pkg::OP_READ, 16'h0700, 1);
		chk(bt[0], 8'hff);
	endtask : sc_power

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		sc_bus();
		sc_delivery();
		sc_page_wrap();
		sc_id_page();
		sc_lock();
		sc_power();
		report_and_stop();
	end
endmodule : tb_top
